// ### verilog/cis_pkg.sv
// ****************************************************************
// Shared constants and types for the instruction execution unit
// ****************************************************************
package cis_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int CC_W   = 5;

  // ****************************************************************
  // Condition-code field positions
  // ****************************************************************
  localparam int CC_C = 0;
  localparam int CC_Z = 1;
  localparam int CC_N = 2;
  localparam int CC_I = 3;
  localparam int CC_H = 4;

  // ****************************************************************
  // Reset values and fixed figures
  // ****************************************************************
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [4:0]  CC_RST  = 5'h08;   // Mask set out of reset
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [15:0] SP_RST  = 16'h01FF;
  localparam logic [15:0] ZP_TOP  = 16'h00FF; // Highest short address
  localparam logic [15:0] SP_STEP = 16'h0002; // Two bytes per return address

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  typedef enum logic [4:0] {
    nop_op,
    add_op,
    add_carry_op,
    sub_op,
    subtract_borrow_op,
    and_op,
    or_op,
    xor_op,
    bit_set_branch,
    call_op,
    relative_call_op,
    negate_op,
    rotate_left_carry_op,
    shift_left_arith_op,
    shift_left_logic_op,
    branch_half_carry_set,
    branch_half_carry_clear,
    branch_mask_set,
    branch_mask_clear,
    branch_negative,
    branch_positive,
    branch_zero_set,
    branch_zero_clear,
    branch_carry_set,
    branch_carry_clear,
    branch_irq_line_low,
    branch_irq_line_high
  } cis_op_t;

endpackage

// ### verilog/cis_exec.sv
// Function
// - Add sums accumulator and operand, carry form adds C; sets H,N,Z,C.
// - Subtract removes operand, borrow form also removes C; sets N,Z,C.
// - AND, OR, XOR combine accumulator with operand; only N,Z change.
// - Bit-set branch jumps when selected bit is one; bit copied to C.
// - Calls push return PC; relative adds displacement, absolute loads target.
// - Negate gives inverted operand plus one; sets N,Z,C.
// - Half-carry branches jump on H set, or on H clear.
// - Mask branches jump on I set, or on I clear.
// - Sign branches jump on N set (minus) or N clear (plus).
// - Equality branches jump on Z set or Z clear.
// - Carry branches jump on C set, or on C clear.
// - Line branches sample interrupt pin; jump on low or high.
// - Rotate left through carry: old C to bit0, bit7 to C; N,Z.
// - Arithmetic left shift equals logical: zero in, bit7 to C; N,Z,C.
// - Short addressing reaches only the zero page up to its top.
`timescale 1ns/100ps
module cis_exec #(
  parameter logic [15:0] PC_RESET = cis_pkg::PC_RST,
  parameter logic [15:0] SP_RESET = cis_pkg::SP_RST
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Operation request
  input  wire logic                        op_valid,
  input  wire cis_pkg::cis_op_t            op_code,
  input  wire logic [cis_pkg::DATA_W-1:0]  op_operand,
  input  wire logic [2:0]                  op_bit,
  input  wire logic [cis_pkg::DATA_W-1:0]  op_disp,
  input  wire logic [cis_pkg::ADDR_W-1:0]  op_target,
  input  wire logic [1:0]                  op_len,
  input  wire logic [cis_pkg::ADDR_W-1:0]  op_addr,
  input  wire logic                        op_short,
  // Flag load from the core
  input  wire logic                        flag_load,
  input  wire logic [cis_pkg::CC_W-1:0]    flag_value,
  // External interrupt pin
  input  wire logic                        irq_pin,
  // Architectural state
  output logic [cis_pkg::DATA_W-1:0]       acc,
  output logic [cis_pkg::CC_W-1:0]         cc,
  output logic [cis_pkg::ADDR_W-1:0]       pc,
  output logic [cis_pkg::ADDR_W-1:0]       sp,
  // Memory operand result and address
  output logic [cis_pkg::DATA_W-1:0]       result,
  output logic                             result_valid,
  output logic [cis_pkg::ADDR_W-1:0]       mem_addr,
  // Stack push of a return address
  output logic                             push_valid,
  output logic [cis_pkg::ADDR_W-1:0]       push_addr,
  output logic [cis_pkg::ADDR_W-1:0]       push_data,
  // Completion strobes
  output logic                             op_done,
  output logic                             branch_taken
);
  import cis_pkg::*;

  // ****************************************************************
  // Interrupt pin synchroniser
  // ****************************************************************
  logic irq_meta;
  logic irq_sync;

  // Pin is asynchronous; only the second stage is read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
    end else begin
      irq_meta <= irq_pin;
      irq_sync <= irq_meta;
    end
  end

  // ****************************************************************
  // Next-state computation
  // ****************************************************************
  logic [ADDR_W-1:0] seq_pc;
  logic [ADDR_W-1:0] rel_pc;
  logic [ADDR_W-1:0] disp_ext;
  logic [8:0]        wide;
  logic [4:0]        nib;
  logic [7:0]        uval;
  logic              cin;
  logic              taken;
  logic              do_push;
  logic              do_result;
  logic [DATA_W-1:0] next_acc;
  logic [CC_W-1:0]   next_cc;
  logic [ADDR_W-1:0] next_pc;

  // Address of the following instruction and the branch target
  always_comb begin
    seq_pc   = pc + {14'h0000, op_len};
    disp_ext = {{8{op_disp[7]}}, op_disp};
    rel_pc   = seq_pc + disp_ext;
  end

  // One decode for all operations; flags default to held values
  always_comb begin
    next_acc  = acc;
    next_cc   = cc;
    taken     = 1'b0;
    do_push   = 1'b0;
    do_result = 1'b0;
    wide      = 9'h000;
    nib       = 5'h00;
    uval      = 8'h00;
    cin       = 1'b0;
    case (op_code)
      add_op, add_carry_op: begin
        cin          = (op_code == add_carry_op) ? cc[CC_C] : 1'b0;
        wide         = {1'b0, acc} + {1'b0, op_operand} + {8'h00, cin};
        nib          = {1'b0, acc[3:0]} + {1'b0, op_operand[3:0]} + {4'h0, cin};
        next_acc     = wide[7:0];
        next_cc[CC_H] = nib[4];
        next_cc[CC_N] = wide[7];
        next_cc[CC_Z] = (wide[7:0] == 8'h00);
        next_cc[CC_C] = wide[8];
      end
      sub_op, subtract_borrow_op: begin
        cin          = (op_code == subtract_borrow_op) ? cc[CC_C] : 1'b0;
        wide         = {1'b0, acc} - {1'b0, op_operand} - {8'h00, cin};
        next_acc     = wide[7:0];
        next_cc[CC_N] = wide[7];
        next_cc[CC_Z] = (wide[7:0] == 8'h00);
        next_cc[CC_C] = wide[8];                            // Borrow out
      end
      and_op, or_op, xor_op: begin
        if (op_code == and_op) begin
          uval = acc & op_operand;
        end else if (op_code == or_op) begin
          uval = acc | op_operand;
        end else begin
          uval = acc ^ op_operand;
        end
        next_acc      = uval;
        next_cc[CC_N] = uval[7];
        next_cc[CC_Z] = (uval == 8'h00);
      end
      bit_set_branch: begin
        next_cc[CC_C] = op_operand[op_bit];
        taken         = op_operand[op_bit];
      end
      call_op, relative_call_op: begin
        do_push = 1'b1;
      end
      negate_op: begin
        uval          = (op_operand ^ 8'hFF) + 8'h01;
        do_result     = 1'b1;
        next_cc[CC_N] = uval[7];
        next_cc[CC_Z] = (uval == 8'h00);
        next_cc[CC_C] = (uval != 8'h00);
      end
      rotate_left_carry_op: begin
        uval          = {op_operand[6:0], cc[CC_C]};
        do_result     = 1'b1;
        next_cc[CC_C] = op_operand[7];
        next_cc[CC_N] = uval[7];
        next_cc[CC_Z] = (uval == 8'h00);
      end
      shift_left_arith_op, shift_left_logic_op: begin
        uval          = {op_operand[6:0], 1'b0};
        do_result     = 1'b1;
        next_cc[CC_C] = op_operand[7];
        next_cc[CC_N] = uval[7];
        next_cc[CC_Z] = (uval == 8'h00);
      end
      branch_half_carry_set:   taken = cc[CC_H];
      branch_half_carry_clear: taken = !cc[CC_H];
      branch_mask_set:         taken = cc[CC_I];
      branch_mask_clear:       taken = !cc[CC_I];
      branch_negative:         taken = cc[CC_N];
      branch_positive:         taken = !cc[CC_N];
      branch_zero_set:         taken = cc[CC_Z];
      branch_zero_clear:       taken = !cc[CC_Z];
      branch_carry_set:        taken = cc[CC_C];
      branch_carry_clear:      taken = !cc[CC_C];
      branch_irq_line_low:     taken = !irq_sync;
      branch_irq_line_high:    taken = irq_sync;
      default: begin
        next_acc = acc;
      end
    endcase
  end

  // Program counter selection
  always_comb begin
    if (op_code == call_op) begin
      next_pc = op_target;
    end else if (op_code == relative_call_op) begin
      next_pc = rel_pc;
    end else if (taken) begin
      next_pc = rel_pc;
    end else begin
      next_pc = seq_pc;
    end
  end

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc <= ACC_RST;
    end else if (op_valid) begin
      acc <= next_acc;
    end
  end

  // ****************************************************************
  // Condition codes
  // ****************************************************************
  // A valid operation wins over a load in the same cycle, so an
  // executed result is never overwritten by a stale image
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cc <= CC_RST;
    end else if (op_valid) begin
      cc <= next_cc;
    end else if (flag_load) begin
      cc <= flag_value;
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc <= PC_RESET;
    end else if (op_valid) begin
      pc <= next_pc;
    end
  end

  // ****************************************************************
  // Stack pointer and return-address push
  // ****************************************************************
  // No wrap guard: deep nesting runs below the stack area unchecked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp <= SP_RESET;
    end else if (op_valid && do_push) begin
      sp <= sp - SP_STEP;
    end
  end

  // Push strobe carries the return address and the old top of stack
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      push_valid <= 1'b0;
      push_addr  <= 16'h0000;
      push_data  <= 16'h0000;
    end else begin
      push_valid <= op_valid && do_push;
      if (op_valid && do_push) begin
        push_addr <= sp;
        push_data <= seq_pc;
      end
    end
  end

  // ****************************************************************
  // Memory operand result and address
  // ****************************************************************
  // Short form masks to the zero page so it cannot reach higher RAM
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result       <= 8'h00;
      result_valid <= 1'b0;
      mem_addr     <= 16'h0000;
    end else begin
      result_valid <= op_valid && do_result;
      if (op_valid) begin
        mem_addr <= op_short ? (op_addr & ZP_TOP) : op_addr;
      end
      if (op_valid && do_result) begin
        result <= uval;
      end
    end
  end

  // ****************************************************************
  // Completion strobes
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_done      <= 1'b0;
      branch_taken <= 1'b0;
    end else begin
      op_done      <= op_valid;
      branch_taken <= op_valid && taken;
    end
  end

endmodule

// ### verif/cis_exec_asserts.sv
`timescale 1ns/100ps
// ********
// Port checker for the execution unit
// ********
module cis_exec_asserts (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rstn,
  // Request side
  input wire logic             op_valid,
  input wire cis_pkg::cis_op_t op_code,
  input wire logic [7:0]       op_operand,
  input wire logic [2:0]       op_bit,
  input wire logic [7:0]       op_disp,
  input wire logic [1:0]       op_len,
  input wire logic             op_short,
  input wire logic             flag_load,
  // State and strobes
  input wire logic [7:0]       acc,
  input wire logic [4:0]       cc,
  input wire logic [15:0]      pc,
  input wire logic [15:0]      sp,
  input wire logic [7:0]       result,
  input wire logic [15:0]      mem_addr,
  input wire logic             push_valid,
  input wire logic [15:0]      push_data,
  input wire logic             branch_taken
);
  import cis_pkg::*;
  logic [15:0] seq_pc;
  logic [15:0] jmp_pc;
  logic        sel_bit;
  logic        c_in;
  // Next and target addresses of the offered op
  assign seq_pc  = pc + {14'h0000, op_len};
  assign jmp_pc  = seq_pc + {{8{op_disp[7]}}, op_disp};
  assign sel_bit = op_operand[op_bit];
  assign c_in    = cc[CC_C];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_idle_hold: assert property (
    !op_valid && !flag_load |=> $stable(cc) && $stable(acc)) else $error("idle state moved");
  chk_add_sum: assert property (
    op_valid && op_code == add_op |=> acc == $past(acc) + $past(op_operand))
    else $error("add sum wrong");
  chk_sub_diff: assert property (
    op_valid && op_code == subtract_borrow_op
    |=> acc == $past(acc) - $past(op_operand) - $past(c_in)) else $error("borrow diff wrong");
  chk_logic_carry: assert property (
    op_valid && op_code inside {and_op, or_op, xor_op} |=> c_in == $past(c_in))
    else $error("logic op moved carry");
  chk_bit_carry: assert property (
    op_valid && op_code == bit_set_branch
    |=> c_in == $past(sel_bit) && branch_taken == $past(sel_bit)) else $error("bit test wrong");
  chk_call_push: assert property (
    op_valid && op_code inside {call_op, relative_call_op}
    |=> push_valid && push_data == $past(seq_pc) && sp == $past(sp) - 16'h0002)
    else $error("call push wrong");
  chk_neg_value: assert property (
    op_valid && op_code == negate_op |=> result == 8'h00 - $past(op_operand))
    else $error("negate wrong");
  chk_zero_branch: assert property (
    op_valid && op_code == branch_zero_set && cc[CC_Z] |=> branch_taken && pc == $past(jmp_pc))
    else $error("zero branch not taken");
  chk_fail_seq: assert property (
    op_valid && op_code == branch_carry_clear && c_in |=> !branch_taken && pc == $past(seq_pc))
    else $error("failed branch moved pc");
  chk_short_page: assert property (
    op_valid && op_short |=> mem_addr <= ZP_TOP) else $error("short address off page");

  // Main scenarios reached
  cover property (op_valid && op_code == bit_set_branch ##1 branch_taken);
  cover property (push_valid);
  cover property (op_valid && op_short);
endmodule

bind cis_exec cis_exec_asserts i_chk (
  .clk, .rstn, .op_valid, .op_code, .op_operand, .op_bit, .op_disp, .op_len, .op_short,
  .flag_load, .acc, .cc, .pc, .sp, .result, .mem_addr, .push_valid, .push_data, .branch_taken
);

// ### verif/test_cpu8_instruction_semantics.sv
`timescale 1ns/100ps
module test_cpu8_instruction_semantics;
  import cis_pkg::*;
  // ********
  // Expected outcome of one op
  // ********
  typedef struct {
    logic [7:0]  acc, res;
    logic [4:0]  cc;
    logic [15:0] pc, sp, pd, ma, pa;
    logic        rv, pv, tk;
  } cis_exp_t;
  logic clk = 0, rstn = 0, op_valid = 0, op_short = 0, flag_load = 0, irq_pin = 1;
  cis_op_t op_code = nop_op;
  logic [7:0] op_operand = 8'h00, op_disp = 8'h00, acc, result;
  logic [2:0] op_bit = 3'h0;
  logic [1:0] op_len = 2'h2;
  logic [4:0] flag_value = 5'h00, cc;
  logic [15:0] op_target = 16'h0000, op_addr = 16'h0000, pc, sp, mem_addr, push_addr, push_data;
  logic result_valid, push_valid, op_done, branch_taken, m_irq = 1;
  logic [7:0] rnd = 8'h49;
  cis_exp_t q[$];
  cis_exp_t m, e;
  int num_errors = 0, num_checks = 0;

  cis_exec i_dut (.clk, .rstn, .op_valid, .op_code, .op_operand, .op_bit, .op_disp,
    .op_target, .op_len, .op_addr, .op_short, .flag_load, .flag_value, .irq_pin, .acc,
    .cc, .pc, .sp, .result, .result_valid, .mem_addr, .push_valid, .push_addr,
    .push_data, .op_done, .branch_taken);

  initial begin
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cmp(string nm, logic [15:0] ex, logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Model one op, note the outcome, drive it at the next edge
  task automatic do_op(cis_op_t c, logic [7:0] v);
    logic [8:0] s;
    logic [4:0] h;
    logic [15:0] nx;
    logic ci;
    logic tk;
    logic [1:0] ln;
    rnd = lfsr(lfsr(rnd));
    ci = m.cc[CC_C];
    // Instruction length varies so the next-address sum is exercised
    ln = (rnd[1:0] == 2'h0) ? 2'h1 : rnd[1:0];
    nx = m.pc + {14'h0000, ln};
    tk = 0;
    m.rv = 0;
    m.pv = 0;
    m.ma = rnd[2] ? {8'h00, rnd} : {v, rnd};
    case (c)
      add_op, add_carry_op: begin
        if (c == add_op) ci = 0;
        s = m.acc + v + ci;
        h = m.acc[3:0] + v[3:0] + ci;
        m.cc[CC_H] = h[4];
        m.cc[CC_C] = s[8];
        m.acc = s[7:0];
      end
      sub_op, subtract_borrow_op: begin
        if (c == sub_op) ci = 0;
        s = m.acc - v - ci;
        m.cc[CC_C] = s[8];
        m.acc = s[7:0];
      end
      and_op: m.acc = m.acc & v;
      or_op: m.acc = m.acc | v;
      xor_op: m.acc = m.acc ^ v;
      bit_set_branch: begin
        tk = v[rnd[6:4]];
        m.cc[CC_C] = tk;
      end
      call_op, relative_call_op: begin
        m.pv = 1;
        m.pd = nx;
        m.pa = m.sp; // Old top of stack
        m.sp = m.sp - 16'h0002;
      end
      negate_op: begin
        m.rv = 1;
        m.res = ~v + 8'h01;
        m.cc[CC_C] = v != 8'h00;
      end
      rotate_left_carry_op, shift_left_arith_op, shift_left_logic_op: begin
        m.rv = 1;
        m.res = {v[6:0], c == rotate_left_carry_op && ci};
        m.cc[CC_C] = v[7];
      end
      branch_half_carry_set: tk = m.cc[CC_H];
      branch_half_carry_clear: tk = !m.cc[CC_H];
      branch_mask_set: tk = m.cc[CC_I];
      branch_mask_clear: tk = !m.cc[CC_I];
      branch_negative: tk = m.cc[CC_N];
      branch_positive: tk = !m.cc[CC_N];
      branch_zero_set: tk = m.cc[CC_Z];
      branch_zero_clear: tk = !m.cc[CC_Z];
      branch_carry_set: tk = m.cc[CC_C];
      branch_carry_clear: tk = !m.cc[CC_C];
      branch_irq_line_low: tk = !m_irq;
      branch_irq_line_high: tk = m_irq;
      default: tk = 0;
    endcase
    if (c inside {[add_op:xor_op]}) m.cc[CC_N:CC_Z] = {m.acc[7], m.acc == 8'h00};
    if (m.rv) m.cc[CC_N:CC_Z] = {m.res[7], m.res == 8'h00};
    m.pc = tk || c == relative_call_op ? nx + {{8{rnd[7]}}, rnd} : nx;
    if (c == call_op) m.pc = {rnd, v};
    m.tk = tk;
    q.push_back(m);
    @(posedge clk);
    op_valid <= 1;
    op_code <= c;
    op_operand <= v;
    op_bit <= rnd[6:4];
    op_disp <= rnd;
    op_len <= ln;
    op_target <= {rnd, v};
    op_addr <= {v, rnd};
    op_short <= rnd[2];
    flag_load <= rnd[1]; // Ignored while an op is offered
    flag_value <= rnd[4:0];
  endtask

  task automatic load_flags(logic [4:0] v);
    @(posedge clk);
    op_valid <= 0;
    flag_load <= 1;
    flag_value <= v;
    m.cc = v;
  endtask

  // Pin settles through the two-stage synchroniser before use
  task automatic idle(logic irq);
    @(posedge clk);
    op_valid <= 0;
    flag_load <= 0;
    irq_pin <= irq;
    repeat (3) @(posedge clk);
    m_irq = irq;
  endtask

  // Scoreboard: oldest note against each completed op
  always @(negedge clk) begin
    if (rstn && op_done && q.size() == 0) begin
      num_errors++;
      $display("Error op_done expected 0 seen 1");
    end else if (rstn && op_done) begin
      e = q.pop_front();
      cmp("acc", e.acc, acc);
      cmp("cc", e.cc, cc);
      cmp("pc", e.pc, pc);
      cmp("sp", e.sp, sp);
      cmp("mem_addr", e.ma, mem_addr);
      cmp("taken", e.tk, branch_taken);
      cmp("push_valid", e.pv, push_valid);
      cmp("result_valid", e.rv, result_valid);
      if (e.pv) cmp("push_data", e.pd, push_data);
      if (e.pv) cmp("push_addr", e.pa, push_addr);
      if (e.rv) cmp("result", e.res, result);
    end
  end

  task automatic wrap_up();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    m.acc = 8'h00;
    m.cc = 5'h08;
    m.pc = 16'h0000;
    m.sp = 16'h01FF;
    repeat (3) @(posedge clk);
    rstn <= 1;
    @(negedge clk);
    cmp("reset cc", 16'h0008, cc);
    cmp("reset sp", 16'h01FF, sp);
    do_op(negate_op, 8'h00);
    do_op(add_op, 8'hFF);
    do_op(add_carry_op, 8'h01);
    do_op(subtract_borrow_op, 8'hFF);
    for (int i = 0; i < 600; i++) begin
      rnd = lfsr(rnd);
      if (rnd[7:5] == 3'h0) load_flags(rnd[4:0]);
      if (i % 40 == 39) idle(rnd[3]);
      do_op(cis_op_t'(rnd % 27), lfsr(rnd) ^ 8'h3C);
    end
    idle(1'b1);
    for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge clk);
    if (q.size() != 0) begin
      num_errors++;
      $display("Error pending ops expected 0 seen %0d", q.size());
    end
    wrap_up();
  end
endmodule
